// File: design/fis_fault_irq.sv
module fis_fault_irq #(
  parameter int         AF_SEL_W   = 2,
  parameter logic [1:0] BUTTON_SEL = 2'h1
) (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  // register access port
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  output logic                     reg_rvalid,
  // event pulses
  input  wire logic                emergency_powerdown_event,
  input  wire logic                watchdog_violation_event,
  input  wire logic                packet_check_miscompare_event,
  input  wire logic                alarm_event,
  input  wire logic                runtime_crc_fault_event,
  input  wire logic                selftest_fault_event,
  input  wire logic                double_error_event,
  input  wire logic                button_short_pulse_event,
  input  wire logic [7:0]          vendor_fault_event,
  // fault condition levels
  input  wire logic                enable_pin_short,
  input  wire logic                crystal_fault,
  input  wire logic                output_pin_fault,
  input  wire logic                regulator_fault,
  input  wire logic                thermal_shutdown,
  // configuration
  input  wire logic [1:0]          watchdog_enable_field,
  input  wire logic                packet_check_enable,
  input  wire logic                alarm_wake_enable,
  input  wire logic                alarm_powerup_enable,
  input  wire logic [31:0]         alarm_value,
  input  wire logic                crystal_enable,
  input  wire logic                regulator_used,
  input  wire logic                alt_function_enable_12,
  input  wire logic [AF_SEL_W-1:0] alt_function_select_12,
  input  wire logic [6:0]          stored_bus_address,
  input  wire logic [1:0]          soc_interface_select,
  // interrupt pin
  output logic                     interrupt_out_n
);

  typedef struct packed {
    logic       irq_n;
    logic [7:0] rdata;
    logic       rvalid;
  } fis_state_t;

  fis_state_t                        state;
  fis_state_t                        next_state;
  logic [fis_pkg::BANK_FLAGS-1:0]    set;
  logic [fis_pkg::BANK_FLAGS-1:0]    clr;
  logic [fis_pkg::BANK_FLAGS-1:0]    flags;
  logic [7:0]                        primary_view;
  logic [7:0]                        internal_view;
  logic [7:0]                        vendor_view;
  logic                              alarm_enabled;
  logic                              button_enabled;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_addr);
    addr_is = (a == ref_addr);
  endfunction : addr_is

  assign alarm_enabled  = alarm_wake_enable | alarm_powerup_enable
                        | (alarm_value != fis_pkg::ALARM_DISABLED);
  assign button_enabled = alt_function_enable_12 & (alt_function_select_12 == BUTTON_SEL);

  // set vector: levels keep re-setting, so a clear only holds once the fault is gone
  always_comb begin
    set = '0;
    set[fis_pkg::PRIM_BASE + fis_pkg::PRIM_EMPD_BIT]   = emergency_powerdown_event;
    set[fis_pkg::PRIM_BASE + fis_pkg::PRIM_WDT_BIT]    = watchdog_violation_event
                                                       & (watchdog_enable_field != fis_pkg::WDT_DISABLED);
    set[fis_pkg::PRIM_BASE + fis_pkg::PRIM_PEC_BIT]    = packet_check_miscompare_event
                                                       & packet_check_enable;
    set[fis_pkg::PRIM_BASE + fis_pkg::PRIM_RTC_BIT]    = alarm_event & alarm_enabled;
    set[fis_pkg::PRIM_BASE + fis_pkg::PRIM_ENPIN_BIT]  = enable_pin_short;
    set[fis_pkg::PRIM_BASE + fis_pkg::PRIM_XTAL_BIT]   = crystal_fault & crystal_enable;
    set[fis_pkg::PRIM_BASE + fis_pkg::PRIM_OUTPIN_BIT] = output_pin_fault;
    set[fis_pkg::INTL_BASE + fis_pkg::INTL_CRC_BIT]    = runtime_crc_fault_event;
    set[fis_pkg::INTL_BASE + fis_pkg::INTL_BIST_BIT]   = selftest_fault_event;
    set[fis_pkg::INTL_BASE + fis_pkg::INTL_LDO_BIT]    = regulator_fault & regulator_used;
    set[fis_pkg::INTL_BASE + fis_pkg::INTL_TSD_BIT]    = thermal_shutdown;
    set[fis_pkg::INTL_BASE + fis_pkg::INTL_ECC_BIT]    = double_error_event;
    set[fis_pkg::INTL_BASE + fis_pkg::INTL_BTN_BIT]    = button_short_pulse_event & button_enabled;
    set[fis_pkg::VEND_BASE +: fis_pkg::VEND_FLAGS]     = vendor_fault_event;
  end

  // write-one clear decode; summary bits and reserved bit take no write
  always_comb begin
    clr = '0;
    if (reg_wr && addr_is(reg_addr, fis_pkg::IRQ_SOURCE_PRIMARY_ADDR)) begin
      clr[fis_pkg::PRIM_BASE +: fis_pkg::PRIM_FLAGS] = reg_wdata[fis_pkg::PRIM_FLAGS-1:0];
    end
    if (reg_wr && addr_is(reg_addr, fis_pkg::IRQ_SOURCE_INTERNAL_ADDR)) begin
      clr[fis_pkg::INTL_BASE +: fis_pkg::INTL_FLAGS] = reg_wdata[fis_pkg::INTL_FLAGS-1:0];
    end
    if (reg_wr && addr_is(reg_addr, fis_pkg::IRQ_SOURCE_VENDOR_ADDR)) begin
      clr[fis_pkg::VEND_BASE +: fis_pkg::VEND_FLAGS] = reg_wdata;
    end
  end

  fis_flag_bank #(
    .WIDTH (fis_pkg::BANK_FLAGS)
  ) u_bank (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .set     (set),
    .clr     (clr),
    .flags   (flags)
  );

  // register views
  always_comb begin
    vendor_view   = flags[fis_pkg::VEND_BASE +: fis_pkg::VEND_FLAGS];
    internal_view = {2'h0, flags[fis_pkg::INTL_BASE +: fis_pkg::INTL_FLAGS]};
    internal_view[fis_pkg::INTL_VENDOR_BIT] = |vendor_view;
    internal_view[fis_pkg::INTL_RSVD_BIT]   = 1'b0;
    internal_view[fis_pkg::INTL_LDO_BIT]    = flags[fis_pkg::INTL_BASE + fis_pkg::INTL_LDO_BIT]
                                            & regulator_used;
    primary_view  = {1'b0, flags[fis_pkg::PRIM_BASE +: fis_pkg::PRIM_FLAGS]};
    primary_view[fis_pkg::PRIM_INTERNAL_BIT] = |internal_view;
    primary_view[fis_pkg::PRIM_XTAL_BIT]     = flags[fis_pkg::PRIM_BASE + fis_pkg::PRIM_XTAL_BIT]
                                             & crystal_enable;
  end

  always_comb begin
    next_state        = state;
    next_state.irq_n  = ~(|primary_view);
    next_state.rvalid = reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        fis_pkg::IRQ_SOURCE_PRIMARY_ADDR: begin
          next_state.rdata = primary_view;
        end
        fis_pkg::IRQ_SOURCE_INTERNAL_ADDR: begin
          next_state.rdata = internal_view;
        end
        fis_pkg::IRQ_SOURCE_VENDOR_ADDR: begin
          next_state.rdata = vendor_view;
        end
        fis_pkg::BUS_ADDRESS_READBACK_ADDR: begin
          next_state.rdata = {1'b0, stored_bus_address};
        end
        fis_pkg::DEVICE_CONFIG_READBACK_ADDR: begin
          next_state.rdata = {6'h00, soc_interface_select};
        end
        default: begin
          next_state.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state.irq_n  <= 1'b1;
      state.rdata  <= fis_pkg::STATUS_RESET;
      state.rvalid <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign interrupt_out_n = state.irq_n;
  assign reg_rdata       = state.rdata;
  assign reg_rvalid      = state.rvalid;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  w1c_clear_a: assert property (
    reg_wr && addr_is(reg_addr, fis_pkg::IRQ_SOURCE_PRIMARY_ADDR)
    && reg_wdata[fis_pkg::PRIM_EMPD_BIT] && !emergency_powerdown_event
    |=> !flags[fis_pkg::PRIM_EMPD_BIT])
    else $error("write one did not clear flag");

  w0_keep_a: assert property (
    flags[fis_pkg::INTL_BASE + fis_pkg::INTL_CRC_BIT]
    && !(reg_wr && addr_is(reg_addr, fis_pkg::IRQ_SOURCE_INTERNAL_ADDR)
         && reg_wdata[fis_pkg::INTL_CRC_BIT])
    |=> flags[fis_pkg::INTL_BASE + fis_pkg::INTL_CRC_BIT])
    else $error("flag lost without write one");

  internal_sum_a: assert property (
    reg_rd && addr_is(reg_addr, fis_pkg::IRQ_SOURCE_PRIMARY_ADDR)
    |=> reg_rvalid && (reg_rdata[fis_pkg::PRIM_INTERNAL_BIT] == $past(|internal_view)))
    else $error("primary top bit not internal summary");

  empd_set_a: assert property (
    emergency_powerdown_event |=> flags[fis_pkg::PRIM_EMPD_BIT] ##1 !interrupt_out_n)
    else $error("emergency flag or interrupt missing");

  wdt_gate_a: assert property (
    watchdog_enable_field == fis_pkg::WDT_DISABLED && !flags[fis_pkg::PRIM_WDT_BIT]
    && !$past(watchdog_enable_field != fis_pkg::WDT_DISABLED)
    |=> !flags[fis_pkg::PRIM_WDT_BIT])
    else $error("watchdog flag set while disabled");

  pec_set_a: assert property (
    packet_check_miscompare_event && packet_check_enable |=> flags[fis_pkg::PRIM_PEC_BIT])
    else $error("miscompare flag not set");

  rtc_gate_a: assert property (
    alarm_event && !alarm_enabled && !flags[fis_pkg::PRIM_RTC_BIT]
    |=> !flags[fis_pkg::PRIM_RTC_BIT])
    else $error("alarm flag set while disabled");

  short_hold_a: assert property (
    enable_pin_short [*2] |-> flags[fis_pkg::PRIM_ENPIN_BIT])
    else $error("short flag cleared while present");

  xtal_zero_a: assert property (
    reg_rd && addr_is(reg_addr, fis_pkg::IRQ_SOURCE_PRIMARY_ADDR) && !crystal_enable
    |=> !reg_rdata[fis_pkg::PRIM_XTAL_BIT])
    else $error("crystal bit reads one while disabled");

  vendor_sum_a: assert property (
    |vendor_view |-> primary_view[fis_pkg::PRIM_INTERNAL_BIT] && internal_view[fis_pkg::INTL_VENDOR_BIT])
    else $error("vendor fault not summarised");

  irq_pin_a: assert property (
    ##1 (interrupt_out_n == !$past(|primary_view)))
    else $error("interrupt pin disagrees with sources");

  set_wins_a: assert property (
    reg_wr && addr_is(reg_addr, fis_pkg::IRQ_SOURCE_PRIMARY_ADDR)
    && reg_wdata[fis_pkg::PRIM_EMPD_BIT] && emergency_powerdown_event
    |=> flags[fis_pkg::PRIM_EMPD_BIT])
    else $error("event lost to simultaneous clear");

  outpin_hold_a: assert property (
    output_pin_fault [*2] |-> flags[fis_pkg::PRIM_BASE + fis_pkg::PRIM_OUTPIN_BIT])
    else $error("pin fault flag cleared while present");

  xtal_hold_a: assert property (
    (crystal_fault && crystal_enable) [*2] |-> primary_view[fis_pkg::PRIM_XTAL_BIT])
    else $error("crystal flag cleared while present");

  ldo_hold_a: assert property (
    (regulator_fault && regulator_used) [*2] |-> internal_view[fis_pkg::INTL_LDO_BIT])
    else $error("regulator flag cleared while present");

  tsd_hold_a: assert property (
    thermal_shutdown [*2] |-> flags[fis_pkg::INTL_BASE + fis_pkg::INTL_TSD_BIT])
    else $error("thermal flag cleared while present");

  crc_set_a: assert property (
    runtime_crc_fault_event |=> flags[fis_pkg::INTL_BASE + fis_pkg::INTL_CRC_BIT])
    else $error("crc flag not set");

  bist_set_a: assert property (
    selftest_fault_event |=> flags[fis_pkg::INTL_BASE + fis_pkg::INTL_BIST_BIT])
    else $error("self-test flag not set");

  ecc_set_a: assert property (
    double_error_event |=> flags[fis_pkg::INTL_BASE + fis_pkg::INTL_ECC_BIT])
    else $error("double error flag not set");

  watchdog_set_a: assert property (
    watchdog_violation_event && watchdog_enable_field != fis_pkg::WDT_DISABLED
    |=> flags[fis_pkg::PRIM_BASE + fis_pkg::PRIM_WDT_BIT])
    else $error("watchdog flag not set");

  rtc_set_a: assert property (
    alarm_event && alarm_enabled |=> flags[fis_pkg::PRIM_BASE + fis_pkg::PRIM_RTC_BIT])
    else $error("alarm flag not set");

  btn_set_a: assert property (
    button_short_pulse_event && button_enabled
    |=> flags[fis_pkg::INTL_BASE + fis_pkg::INTL_BTN_BIT])
    else $error("button flag not set");

  btn_gate_a: assert property (
    button_short_pulse_event && !button_enabled && !flags[fis_pkg::INTL_BASE + fis_pkg::INTL_BTN_BIT]
    |=> !flags[fis_pkg::INTL_BASE + fis_pkg::INTL_BTN_BIT])
    else $error("button flag set while disabled");

  miscompare_gate_a: assert property (
    packet_check_miscompare_event && !packet_check_enable
    && !flags[fis_pkg::PRIM_BASE + fis_pkg::PRIM_PEC_BIT] |=> !flags[fis_pkg::PRIM_BASE + fis_pkg::PRIM_PEC_BIT])
    else $error("miscompare flag set while disabled");

  ldo_read_a: assert property (
    reg_rd && addr_is(reg_addr, fis_pkg::IRQ_SOURCE_INTERNAL_ADDR) && !regulator_used
    |=> !reg_rdata[fis_pkg::INTL_LDO_BIT])
    else $error("regulator bit reads one while unused");

  rvalid_pulse_a: assert property (
    ##1 (reg_rvalid == $past(reg_rd)))
    else $error("read valid not one cycle after read");

  rdata_hold_a: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  vendor_read_a: assert property (
    reg_rd && addr_is(reg_addr, fis_pkg::IRQ_SOURCE_VENDOR_ADDR) |=> reg_rdata == $past(vendor_view))
    else $error("vendor read data wrong");

  internal_read_a: assert property (
    reg_rd && addr_is(reg_addr, fis_pkg::IRQ_SOURCE_INTERNAL_ADDR) |=> reg_rdata == $past(internal_view))
    else $error("internal read data wrong");

  vend_clear_a: assert property (
    reg_wr && addr_is(reg_addr, fis_pkg::IRQ_SOURCE_VENDOR_ADDR) && reg_wdata == 8'hFF
    && vendor_fault_event == 8'h00 |=> vendor_view == 8'h00)
    else $error("vendor flags not cleared by write one");

  top_keep_a: assert property (
    reg_wr && addr_is(reg_addr, fis_pkg::IRQ_SOURCE_PRIMARY_ADDR)
    && flags[fis_pkg::INTL_BASE + fis_pkg::INTL_TSD_BIT]
    |=> primary_view[fis_pkg::PRIM_INTERNAL_BIT])
    else $error("summary bit cleared directly");

  vend_keep_a: assert property (
    reg_wr && addr_is(reg_addr, fis_pkg::IRQ_SOURCE_INTERNAL_ADDR) && |vendor_view
    |=> internal_view[fis_pkg::INTL_VENDOR_BIT])
    else $error("vendor summary cleared directly");

endmodule : fis_fault_irq

// File: design/fis_pkg.sv
package fis_pkg;

  // register offsets
  localparam logic [7:0] IRQ_SOURCE_PRIMARY_ADDR    = 8'h10;
  localparam logic [7:0] IRQ_SOURCE_INTERNAL_ADDR   = 8'h11;
  localparam logic [7:0] IRQ_SOURCE_VENDOR_ADDR     = 8'h12;
  localparam logic [7:0] BUS_ADDRESS_READBACK_ADDR  = 8'hF9;
  localparam logic [7:0] DEVICE_CONFIG_READBACK_ADDR = 8'hFA;

  // reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // primary register bit positions
  localparam int PRIM_INTERNAL_BIT = 7;
  localparam int PRIM_EMPD_BIT     = 6;
  localparam int PRIM_WDT_BIT      = 5;
  localparam int PRIM_PEC_BIT      = 4;
  localparam int PRIM_RTC_BIT      = 3;
  localparam int PRIM_ENPIN_BIT    = 2;
  localparam int PRIM_XTAL_BIT     = 1;
  localparam int PRIM_OUTPIN_BIT   = 0;

  // internal-fault register bit positions
  localparam int INTL_VENDOR_BIT   = 7;
  localparam int INTL_RSVD_BIT     = 6;
  localparam int INTL_CRC_BIT      = 5;
  localparam int INTL_BIST_BIT     = 4;
  localparam int INTL_LDO_BIT      = 3;
  localparam int INTL_TSD_BIT      = 2;
  localparam int INTL_ECC_BIT      = 1;
  localparam int INTL_BTN_BIT      = 0;

  // layout of the sticky flag bank
  localparam int PRIM_FLAGS = 7;
  localparam int INTL_FLAGS = 6;
  localparam int VEND_FLAGS = 8;
  localparam int PRIM_BASE  = 0;
  localparam int INTL_BASE  = PRIM_BASE + PRIM_FLAGS;
  localparam int VEND_BASE  = INTL_BASE + INTL_FLAGS;
  localparam int BANK_FLAGS = VEND_BASE + VEND_FLAGS;

  // field values
  localparam logic [1:0]  WDT_DISABLED   = 2'h0;
  localparam logic [31:0] ALARM_DISABLED = 32'hFFFFFFFF;

endpackage : fis_pkg

// File: design/fis_flag_bank.sv
module fis_flag_bank #(
  parameter int WIDTH = 21
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  // set events and write-one clears
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  // sticky flags
  output logic      [WIDTH-1:0] flags
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } fis_bank_state_t;

  fis_bank_state_t state;
  fis_bank_state_t next_state;

  always_comb begin
    next_state       = state;
    // set applied after clear, so a colliding event survives
    next_state.flags = (state.flags & ~clr) | set;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flags = state.flags;

endmodule : fis_flag_bank

// File: tb/fis_host_model.sv
module fis_host_model (
  // clock
  input  wire logic       sys_clk,
  // register port toward the block
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // one-cycle strobe; idle bus shows inverted leftovers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  // answer sampled on the falling edge, half a cycle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge sys_clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask : rd
endmodule : fis_host_model

// File: tb/fis_fault_irq_tb.sv
module fis_fault_irq_tb;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [7:0] ev;
    logic [7:0] vend;
    logic [4:0] lvl;
    logic [7:0] e10;
    logic [7:0] e11;
    logic [7:0] e12;
  } fis_row_t;

  logic        sys_clk, rstn, reg_wr, reg_rd, reg_rvalid, interrupt_out_n;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, ev, vend, got;
  logic [4:0]  lvl;
  logic [1:0]  wdt_field, af_sel, soc_sel;
  logic        pce, awe, ape, xen, reg_used, afe;
  logic [31:0] alarm_val;
  logic [6:0]  bus_addr;
  int          errors, n_compared, cycles;
  fis_row_t    rows [11];

  fis_host_model u_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  fis_fault_irq u_dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .emergency_powerdown_event(ev[0]), .watchdog_violation_event(ev[1]), .packet_check_miscompare_event(ev[2]),
    .alarm_event(ev[3]), .runtime_crc_fault_event(ev[4]), .selftest_fault_event(ev[5]),
    .double_error_event(ev[6]), .button_short_pulse_event(ev[7]), .vendor_fault_event(vend),
    .enable_pin_short(lvl[0]), .crystal_fault(lvl[1]), .output_pin_fault(lvl[2]), .regulator_fault(lvl[3]),
    .thermal_shutdown(lvl[4]), .watchdog_enable_field(wdt_field), .packet_check_enable(pce),
    .alarm_wake_enable(awe), .alarm_powerup_enable(ape), .alarm_value(alarm_val), .crystal_enable(xen),
    .regulator_used(reg_used), .alt_function_enable_12(afe), .alt_function_select_12(af_sel),
    .stored_bus_address(bus_addr), .soc_interface_select(soc_sel), .interrupt_out_n(interrupt_out_n));

  always #2.5 sys_clk = ~sys_clk;

  task automatic close_out();
    $display("TB: %0d compared, %0d errors", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      close_out();
    end
  end

  task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] seen);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : cmp8

  task automatic cmp1(input string name, input logic exp, input logic seen);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", name, exp, seen);
    end
  endtask : cmp1

  task automatic check_regs(input logic [7:0] e10, input logic [7:0] e11, input logic [7:0] e12);
    u_host.rd(8'h10, got);
    cmp8("irq_source_primary", e10, got);
    u_host.rd(8'h11, got);
    cmp8("irq_source_internal", e11, got);
    u_host.rd(8'h12, got);
    cmp8("irq_source_vendor", e12, got);
  endtask : check_regs

  task automatic pulse(input logic [7:0] e, input logic [7:0] v, input logic [4:0] l);
    @(negedge sys_clk);
    ev   = e;
    vend = v;
    lvl  = l;
    @(negedge sys_clk);
    ev   = 8'h00;
    vend = 8'h00;
    lvl  = 5'h00;
  endtask : pulse

  task automatic clear_all();
    u_host.wr(8'h12, 8'hFF);
    u_host.wr(8'h11, 8'hFF);
    u_host.wr(8'h10, 8'hFF);
  endtask : clear_all

  initial begin
    sys_clk = 1'b0; rstn = 1'b0; ev = 8'h00; vend = 8'h00; lvl = 5'h00;
    wdt_field = 2'h1; pce = 1'b1; awe = 1'b1; ape = 1'b0; alarm_val = 32'h00000000;
    xen = 1'b1; reg_used = 1'b1; afe = 1'b1; af_sel = 2'h1; bus_addr = 7'h5A; soc_sel = 2'h2;
    errors = 0; n_compared = 0; cycles = 0;
    rows = '{'{8'h01, 8'h00, 5'h00, 8'h40, 8'h00, 8'h00},
             '{8'h02, 8'h00, 5'h00, 8'h20, 8'h00, 8'h00},
             '{8'h04, 8'h00, 5'h00, 8'h10, 8'h00, 8'h00},
             '{8'h08, 8'h00, 5'h00, 8'h08, 8'h00, 8'h00},
             '{8'h10, 8'h00, 5'h00, 8'h80, 8'h20, 8'h00},
             '{8'h20, 8'h00, 5'h00, 8'h80, 8'h10, 8'h00},
             '{8'h40, 8'h00, 5'h00, 8'h80, 8'h02, 8'h00},
             '{8'h80, 8'h00, 5'h00, 8'h80, 8'h01, 8'h00},
             '{8'h00, 8'h81, 5'h00, 8'h80, 8'h80, 8'h81},
             '{8'h00, 8'h00, 5'h07, 8'h07, 8'h00, 8'h00},
             '{8'h00, 8'h00, 5'h18, 8'h80, 8'h0C, 8'h00}};
    repeat (5) @(negedge sys_clk);
    rstn = 1'b1;
    check_regs(8'h00, 8'h00, 8'h00);
    cmp1("interrupt_out_n reset", 1'b1, interrupt_out_n);
    u_host.rd(8'h20, got);
    cmp8("unmapped", 8'h00, got);
    u_host.rd(8'hF9, got);
    cmp8("bus_address_readback", {1'b0, bus_addr}, got);
    u_host.rd(8'hFA, got);
    cmp8("device_config_readback", {6'h00, soc_sel}, got);
    $display("TB: reset and readback done");
    foreach (rows[i]) begin
      pulse(rows[i].ev, rows[i].vend, rows[i].lvl);
      check_regs(rows[i].e10, rows[i].e11, rows[i].e12);
      cmp1("interrupt_out_n set", 1'b0, interrupt_out_n);
      clear_all();
      check_regs(8'h00, 8'h00, 8'h00);
      cmp1("interrupt_out_n idle", 1'b1, interrupt_out_n);
      $display("TB: row %0d done", i);
    end
    pulse(8'h01, 8'h00, 5'h00);
    u_host.wr(8'h10, 8'h00);
    u_host.wr(8'h10, 8'hBF);
    check_regs(8'h40, 8'h00, 8'h00);
    fork
      u_host.wr(8'h10, 8'h40);
      pulse(8'h01, 8'h00, 5'h00);
    join
    check_regs(8'h40, 8'h00, 8'h00);
    clear_all();
    $display("TB: write masks done");
    @(negedge sys_clk);
    lvl = 5'h11;
    clear_all();
    check_regs(8'h84, 8'h04, 8'h00);
    lvl = 5'h00;
    clear_all();
    check_regs(8'h00, 8'h00, 8'h00);
    $display("TB: held faults done");
    pulse(8'h00, 8'h00, 5'h02);
    xen = 1'b0;
    check_regs(8'h00, 8'h00, 8'h00);
    xen = 1'b1;
    clear_all();
    wdt_field = 2'h0; pce = 1'b0; awe = 1'b0; alarm_val = 32'hFFFFFFFF; af_sel = 2'h2; xen = 1'b0;
    reg_used = 1'b0;
    pulse(8'h8E, 8'h00, 5'h0A);
    check_regs(8'h00, 8'h00, 8'h00);
    cmp1("interrupt_out_n gated", 1'b1, interrupt_out_n);
    $display("TB: gates done");
    ape = 1'b1;
    pulse(8'h08, 8'h00, 5'h00);
    check_regs(8'h08, 8'h00, 8'h00);
    cmp1("interrupt_out_n alarm", 1'b0, interrupt_out_n);
    ape = 1'b0;
    alarm_val = 32'h00000001;
    af_sel = 2'h1;
    wdt_field = 2'h3;
    clear_all();
    pulse(8'h8A, 8'h00, 5'h00);
    check_regs(8'hA8, 8'h01, 8'h00);
    clear_all();
    $display("TB: alternate enables done");
    pulse(8'h01, 8'h01, 5'h00);
    @(negedge sys_clk);
    rstn = 1'b0;
    repeat (5) @(negedge sys_clk);
    rstn = 1'b1;
    check_regs(8'h00, 8'h00, 8'h00);
    cmp1("interrupt_out_n rereset", 1'b1, interrupt_out_n);
    $display("TB: mid-run reset done");
    close_out();
  end
endmodule : fis_fault_irq_tb
